// file: hw/ddc_clocking.sv
// Purpose: Clocking core of a DDR2 controller: memory clock, two rates, queue
// Assumes: i_clock is the double-rate clock; i_bus_tick marks bus clock edges
// Notes:   Both rates are enables of i_clock, crossing still uses gray pointers
`timescale 1ns/10ps

module ddc_clocking
  import ddc_pkg::*;
(
  input  wire logic                     i_clock,          // Double-rate clock
  input  wire logic                     i_reset,          // Asynchronous reset
  input  wire logic                     i_bus_tick,       // One pulse per bus clock edge
  input  wire logic                     i_cmd_valid,      // Bus command offered
  input  wire logic                     i_cmd_write,      // Bus command is a write
  input  wire logic [DDC_ADDR_W-1:0]    i_cmd_addr,       // Bus byte address
  input  wire logic [2:0]               i_cfg_cas,        // CAS latency in memory cycles
  input  wire logic [1:0]               i_cfg_banks,      // Log2 of internal banks
  input  wire logic [1:0]               i_cfg_page,       // Page code, 0 is 256 columns
  input  wire logic                     i_cfg_narrow,     // High for 16-bit data bus
  input  wire logic [DDC_RATE_W-1:0]    i_refresh_rate,   // Memory cycles per refresh, minus one
  input  wire logic [DDC_BACKLOG_W-1:0] i_backlog_max,    // Backlog that forces refresh
  input  wire logic                     i_self_refresh,   // Request self refresh
  input  wire logic                     i_clock_stop_req, // Request clock stop
  output logic                          o_mem_clk,        // Memory clock, true phase
  output logic                          o_mem_clk_n,      // Memory clock, inverted
  output logic                          o_mem_tick,       // Memory clock rising pulse
  output logic                          o_cmd_ready,      // Queue can take a command
  output logic                          o_mem_cmd_valid,  // Command to memory sequencer
  output logic                          o_mem_cmd_write,  // That command is a write
  output logic [DDC_ADDR_W-1:0]         o_mem_cmd_addr,   // That command's address
  output logic                          o_refresh_pulse,  // Issue one refresh
  output logic [DDC_BACKLOG_W-1:0]      o_backlog,        // Owed refreshes
  output logic                          o_self_refresh,   // Memory in self refresh
  output logic                          o_clock_stop_ack, // Clocks may now stop
  output logic                          o_cfg_error,      // Unsupported CAS setting
  output logic [3:0]                    o_col_bits,       // Column address bits
  output logic [1:0]                    o_bank_bits,      // Bank address bits
  output logic [2:0]                    o_bus_bytes,      // Bytes per memory word
  output logic                          o_odt,            // Termination control
  output logic                          o_dqs_diff_en     // Differential strobe enable
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Binary to gray, used for both queue pointers
  function automatic logic [DDC_PTR_W-1:0] to_gray(input logic [DDC_PTR_W-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  // Supported CAS latency check
  function automatic logic cas_ok(input logic [2:0] cas);
    cas_ok = (cas >= DDC_CAS_MIN) && (cas <= DDC_CAS_MAX);
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic                     mclk;      // Memory clock level
    ddc_state_type            state;     // Memory side state
    logic [DDC_PTR_W-1:0]     wptr;      // Bus side write pointer
    logic [DDC_PTR_W-1:0]     wgray;     // Gray copy of write pointer
    logic [DDC_PTR_W-1:0]     rg_s1;     // Read pointer, first sync stage
    logic [DDC_PTR_W-1:0]     rg_s2;     // Read pointer, second sync stage
    logic [DDC_PTR_W-1:0]     rptr;      // Memory side read pointer
    logic [DDC_PTR_W-1:0]     rgray;     // Gray copy of read pointer
    logic [DDC_PTR_W-1:0]     wg_s1;     // Write pointer, first sync stage
    logic [DDC_PTR_W-1:0]     wg_s2;     // Write pointer, second sync stage
    logic                     rd_pend;   // Fetch in flight
    logic                     cmd_vld;   // Command pulse
    logic                     cmd_wr;    // Command direction
    logic [DDC_ADDR_W-1:0]    cmd_addr;  // Command address
    logic [DDC_RATE_W-1:0]    ref_cnt;   // Cycles since last refresh slot
    logic [DDC_BACKLOG_W-1:0] backlog;   // Owed refreshes
    logic                     ref_pls;   // Refresh pulse
    logic                     cfg_err;   // Registered CAS check
    logic [3:0]               col_bits;  // Registered column width
    logic [1:0]               bank_bits; // Registered bank width
    logic [2:0]               bytes;     // Registered bus width
  } ddc_core_type;

  ddc_core_type r;                       // Current state
  ddc_core_type r_nxt;                   // Next state

  ddc_ram_if ram ();                     // Queue storage link

  logic tick;                            // Memory clock domain enable
  logic q_full;                          // Bus side full view
  logic q_empty;                         // Memory side empty view
  logic bl_full;                         // Backlog at its cap
  logic take;                            // Bus command accepted

  // Memory domain ticks on each rising memory clock, not while stopped
  assign tick    = !r.mclk && (r.state != DDC_ST_STOP);
  // Full compares against the synchronized read pointer only
  assign q_full  = (r.wgray == {~r.rg_s2[DDC_PTR_W-1:DDC_Q_AW-1],
                                r.rg_s2[DDC_Q_AW-2:0]});
  assign q_empty = (r.rgray == r.wg_s2);
  assign bl_full = (r.backlog >= i_backlog_max) && (i_backlog_max != '0);
  assign take    = i_bus_tick && i_cmd_valid && !q_full;

  // Queue storage ports
  assign ram.wr_en   = take;
  assign ram.wr_addr = r.wptr[DDC_Q_AW-1:0];
  assign ram.wr_data = {i_cmd_write, i_cmd_addr};
  assign ram.rd_en   = tick && (r.state == DDC_ST_RUN) && !q_empty && !r.rd_pend
                       && !bl_full && !i_clock_stop_req;
  assign ram.rd_addr = r.rptr[DDC_Q_AW-1:0];

  ddc_cmd_ram u_ram (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .ram     (ram.ram)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    r_nxt         = r;
    r_nxt.cmd_vld = 1'b0;
    r_nxt.ref_pls = 1'b0;
    // Memory clock halves i_clock; it parks low while stopped
    r_nxt.mclk    = (r.state == DDC_ST_STOP) ? 1'b0 : ~r.mclk;
    // Pointer synchronizers: stage one feeds stage two only
    r_nxt.rg_s1   = r.rgray;
    r_nxt.rg_s2   = r.rg_s1;
    r_nxt.wg_s1   = r.wgray;
    r_nxt.wg_s2   = r.wg_s1;
    // Bus side write pointer moves on bus ticks only
    if (take) begin
      r_nxt.wptr  = r.wptr + DDC_PTR_ONE;
      r_nxt.wgray = to_gray(r.wptr + DDC_PTR_ONE);
    end
    // Fetched entry becomes a one-cycle command pulse
    if (r.rd_pend) begin
      r_nxt.rd_pend  = 1'b0;
      r_nxt.cmd_vld  = 1'b1;
      r_nxt.cmd_wr   = ram.rd_data[DDC_ENTRY_W-1];
      r_nxt.cmd_addr = ram.rd_data[DDC_ADDR_W-1:0];
    end
    if (tick) begin
      // Settings are sampled in the memory domain
      r_nxt.cfg_err   = !cas_ok(i_cfg_cas);
      r_nxt.col_bits  = DDC_COL_BASE + {2'h0, i_cfg_page};
      r_nxt.bank_bits = i_cfg_banks;
      r_nxt.bytes     = i_cfg_narrow ? DDC_BYTES_NARROW : DDC_BYTES_WIDE;
    end
    if (ram.rd_en) begin
      r_nxt.rd_pend = 1'b1;
      r_nxt.rptr    = r.rptr + DDC_PTR_ONE;
      r_nxt.rgray   = to_gray(r.rptr + DDC_PTR_ONE);
    end
    case (r.state)
      DDC_ST_RUN: begin
        if (tick) begin
          // Interval counter adds one owed refresh per period
          if (r.ref_cnt >= i_refresh_rate) begin
            r_nxt.ref_cnt = '0;
            if (r.backlog != '1) begin
              r_nxt.backlog = r.backlog + DDC_BL_ONE;
            end
          end else begin
            r_nxt.ref_cnt = r.ref_cnt + DDC_RATE_ONE;
          end
          // Refresh goes out when idle, or first when backlog is capped
          if ((bl_full || (q_empty && !r.rd_pend)) && r.backlog != '0) begin
            r_nxt.ref_pls = 1'b1;
            // Builds on the next value so a slot landing now is not lost
            r_nxt.backlog = r_nxt.backlog - DDC_BL_ONE;
          end
          // Leave only with an empty queue, nothing in flight, no refresh going out
          if (q_empty && !r.rd_pend && !r.cmd_vld && !r_nxt.ref_pls) begin
            if (i_self_refresh) begin
              r_nxt.state   = DDC_ST_SELF;
              r_nxt.backlog = '0;
            end else if (i_clock_stop_req) begin
              r_nxt.state = DDC_ST_STOP;
              // Park low now, so the stopped clock never shows a high phase
              r_nxt.mclk  = 1'b0;
            end
          end
        end
      end
      DDC_ST_STOP: begin
        // No ticks here; resume as soon as the request drops
        if (!i_clock_stop_req) begin
          r_nxt.state = DDC_ST_RUN;
        end
      end
      DDC_ST_SELF: begin
        // Memory keeps its own rows; interval counter restarts on exit
        r_nxt.ref_cnt = '0;
        if (tick && !i_self_refresh) begin
          r_nxt.state = DDC_ST_RUN;
        end
      end
      default: begin
        r_nxt.state = DDC_ST_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign o_mem_clk        = r.mclk;
  assign o_mem_clk_n      = ~r.mclk;
  assign o_mem_tick       = tick;
  assign o_cmd_ready      = !q_full;
  assign o_mem_cmd_valid  = r.cmd_vld;
  assign o_mem_cmd_write  = r.cmd_wr;
  assign o_mem_cmd_addr   = r.cmd_addr;
  assign o_refresh_pulse  = r.ref_pls;
  assign o_backlog        = r.backlog;
  assign o_self_refresh   = (r.state == DDC_ST_SELF);
  assign o_clock_stop_ack = (r.state == DDC_ST_STOP);
  assign o_cfg_error      = r.cfg_err;
  assign o_col_bits       = r.col_bits;
  assign o_bank_bits      = r.bank_bits;
  assign o_bus_bytes      = r.bytes;
  // Termination is absent, so its control never leaves low
  assign o_odt            = 1'b0;
  // Strobes are single ended; DDR2 only, no other memory type decode
  assign o_dqs_diff_en    = 1'b0;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking dc @(posedge i_clock); endclocking
  default disable iff (i_reset);

  a_clk_fall_next:  assert property (o_mem_clk |=> !o_mem_clk)
    else $error("memory clock high for more than one cycle");
  a_clk_pair_inv:   assert property (o_mem_clk_n == !o_mem_clk)
    else $error("memory clock pair not complementary");
  a_odt_held_low:   assert property (!o_odt && !o_dqs_diff_en)
    else $error("termination or differential strobe driven");
  a_full_no_write:  assert property (ram.wr_en
                                     |-> DDC_PTR_W'(r.wptr - r.rptr) < DDC_Q_DEPTH)
    else $error("queue written while full");
  a_fetch_to_cmd:   assert property (ram.rd_en |=> ##1 o_mem_cmd_valid)
    else $error("fetched entry not issued two cycles later");
  a_stop_quiet:     assert property (o_clock_stop_ack |-> !o_mem_cmd_valid
                                     && !o_refresh_pulse && !o_mem_clk)
    else $error("activity while clocks stopped");
  a_urgent_refresh: assert property ((tick && bl_full && r.state == DDC_ST_RUN)
                                     |=> o_refresh_pulse)
    else $error("capped backlog did not force a refresh");
  a_cas_check:      assert property (tick |=> o_cfg_error == !cas_ok($past(i_cfg_cas)))
    else $error("CAS latency check wrong");
  a_ptr_sync_two:   assert property (r.wg_s2 == $past(r.wgray, 2))
    else $error("write pointer crossing not two stages");

endmodule

// file: hw/ddc_cmd_ram.sv
// Purpose: Storage for the command queue, registered read
// Assumes: Write and read address never collide on one entry in one cycle
// Notes:   Read data appear one cycle after rd_en
`timescale 1ns/10ps

module ddc_cmd_ram
  import ddc_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_reset,
  ddc_ram_if.ram    ram
);

  // ==========================================================================
  // Storage state
  // ==========================================================================
  typedef struct packed {
    logic [DDC_Q_DEPTH-1:0][DDC_ENTRY_W-1:0] mem;      // Queue entries
    logic [DDC_ENTRY_W-1:0]                  rd;       // Read data register
  } ddc_ram_state_type;

  ddc_ram_state_type ram_r;                            // Current contents
  ddc_ram_state_type ram_nxt;                          // Next contents

  // Write and fetch
  always_comb begin
    ram_nxt = ram_r;
    if (ram.wr_en) begin
      ram_nxt.mem[ram.wr_addr] = ram.wr_data;
    end
    if (ram.rd_en) begin
      ram_nxt.rd = ram_r.mem[ram.rd_addr];
    end
  end

  // State register
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      ram_r <= '0;
    end else begin
      ram_r <= ram_nxt;
    end
  end

  assign ram.rd_data = ram_r.rd;

endmodule

// file: hw/ddc_pkg.sv
// Purpose: Shared constants and types for the memory controller clocking block
// Assumes: One fast clock at the double data rate; slower rates are enable pulses
// Notes:   Every width, count and code used by more than one file lives here
package ddc_pkg;

  // ==========================================================================
  // Clock division
  // ==========================================================================
  localparam int unsigned DDC_MEM_DIV        = 2;      // Double-rate to memory clock ratio
  localparam int unsigned DDC_BUS_DIV        = 3;      // Double-rate cycles per bus clock edge
  localparam int unsigned DDC_CLK_PERIOD_NS  = 100;    // Clock period of i_clock

  // ==========================================================================
  // Supported memory envelope
  // ==========================================================================
  localparam int unsigned DDC_ADDR_W         = 28;     // 256 Mbyte byte address space
  localparam logic [2:0]  DDC_CAS_MIN        = 3'h2;   // Least CAS latency
  localparam logic [2:0]  DDC_CAS_MAX        = 3'h5;   // Largest CAS latency
  localparam logic [3:0]  DDC_COL_BASE       = 4'h8;   // Page code 0 means 256 columns
  localparam logic [2:0]  DDC_BYTES_WIDE     = 3'h4;   // 32-bit data bus
  localparam logic [2:0]  DDC_BYTES_NARROW   = 3'h2;   // 16-bit data bus

  // ==========================================================================
  // Command queue between the two rates
  // ==========================================================================
  localparam int unsigned DDC_Q_AW           = 2;      // Entry index width
  localparam int unsigned DDC_Q_DEPTH        = 4;      // Entries in the command queue
  localparam int unsigned DDC_PTR_W          = 3;      // Pointer width with wrap bit
  localparam int unsigned DDC_ENTRY_W        = 29;     // Write flag plus byte address
  localparam int unsigned DDC_RATE_W         = 8;      // Refresh interval counter width
  localparam int unsigned DDC_BACKLOG_W      = 4;      // Refresh backlog counter width

  localparam logic [DDC_PTR_W-1:0]     DDC_PTR_ZERO = 3'h0;
  localparam logic [DDC_PTR_W-1:0]     DDC_PTR_ONE  = 3'h1;
  localparam logic [DDC_RATE_W-1:0]    DDC_RATE_ONE = 8'h01;
  localparam logic [DDC_BACKLOG_W-1:0] DDC_BL_ONE   = 4'h1;

  // Memory side operating states
  typedef enum logic [1:0] {
    DDC_ST_RUN  = 2'b00,                               // Normal command service
    DDC_ST_STOP = 2'b01,                               // Clocks stopped, entered only with the queue drained
    DDC_ST_SELF = 2'b10                                // Memory refreshes itself
  } ddc_state_type;

endpackage

// file: hw/ddc_ram_if.sv
// Purpose: Carrier between the clocking top and its command queue storage
// Assumes: Both ends run on the one i_clock
// Notes:   Write side belongs to bus-rate logic, read side to memory-rate logic
`timescale 1ns/10ps

interface ddc_ram_if;
  import ddc_pkg::*;
  logic                   wr_en;    // Store one entry
  logic [DDC_Q_AW-1:0]    wr_addr;  // Entry to store
  logic [DDC_ENTRY_W-1:0] wr_data;  // Entry contents
  logic                   rd_en;    // Fetch one entry
  logic [DDC_Q_AW-1:0]    rd_addr;  // Entry to fetch
  logic [DDC_ENTRY_W-1:0] rd_data;  // Registered fetch result

  modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
  modport ram  (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

// file: sim/ddc_clocking_test.sv
// Purpose: Self-checking bench for the memory controller clocking block
// Assumes: i_clock is the double-rate clock; a bus edge every third cycle
// Notes:   Random commands from a fixed seed, corner cases by hand
`timescale 1ns/10ps

module ddc_clocking_test;
  import ddc_pkg::*;
  // ==========================================================================
  // Nets
  // ==========================================================================
  logic                     i_clock, i_reset, i_bus_tick, i_cmd_valid, i_cmd_write;
  logic [DDC_ADDR_W-1:0]    i_cmd_addr, o_mem_cmd_addr;
  logic [2:0]               i_cfg_cas, o_bus_bytes;
  logic [1:0]               i_cfg_banks, i_cfg_page, o_bank_bits;
  logic [DDC_RATE_W-1:0]    i_refresh_rate;
  logic [DDC_BACKLOG_W-1:0] i_backlog_max, o_backlog;
  logic [3:0]               o_col_bits;
  logic                     i_cfg_narrow, i_self_refresh, i_clock_stop_req, o_mem_clk;
  logic                     o_mem_clk_n, o_mem_tick, o_cmd_ready, o_mem_cmd_valid;
  logic                     o_mem_cmd_write, o_refresh_pulse, o_self_refresh;
  logic                     o_clock_stop_ack, o_cfg_error, o_odt, o_dqs_diff_en;
  logic                     got, fault, started, prev;
  logic [DDC_ENTRY_W-1:0]   word;
  logic [DDC_ENTRY_W-1:0]   expq[$];   // Commands owed to the memory, oldest first
  logic [31:0]              r;
  int                       bad_count, checks_done, seed, cycles, pulses, ngot, i;

  ddc_clocking DUT (.*);

  ddc_mem_model MEM (.i_clock(i_clock), .i_mem_clk(o_mem_clk), .i_mem_clk_n(o_mem_clk_n),
    .i_cmd_valid(o_mem_cmd_valid), .i_cmd_write(o_mem_cmd_write), .i_cmd_addr(o_mem_cmd_addr),
    .i_odt(o_odt), .i_dqs_diff_en(o_dqs_diff_en), .o_got(got), .o_word(word), .o_fault(fault));

  // ==========================================================================
  // Clock, bus edges, timeout
  // ==========================================================================
  // Double-rate clock at the data rate, twice the memory clock
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  // Bus edge every third cycle; ceiling far above the planned run
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    i_bus_tick <= (cycles % DDC_BUS_DIV == 0);
    if (cycles > 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Offer one command and hold it until a bus edge finds room
  task automatic send(input logic wr, input logic [DDC_ADDR_W-1:0] ad);
    @(posedge i_clock);
    i_cmd_valid <= 1'b1;
    i_cmd_write <= wr;
    i_cmd_addr <= ad;
    do @(posedge i_clock); while (!(i_bus_tick === 1'b1 && o_cmd_ready === 1'b1));
    i_cmd_valid <= 1'b0;
    expq.push_back({wr, ad});
  endtask

  // Unsupported CAS latencies raise the error flag
  function automatic logic cas_bad(input int c);
    return (c < DDC_CAS_MIN) || (c > DDC_CAS_MAX);
  endfunction

  // Pins, tick pattern and arriving commands checked every cycle
  always @(negedge i_clock) begin
    if (started) begin
      check(fault, 1'b0);
      check(o_mem_tick, !o_mem_clk && !o_clock_stop_ack);
      pulses += o_refresh_pulse;
      ngot += got;
      if (got === 1'b1) check(word, expq.pop_front());
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    seed = 56647;
    {bad_count, checks_done, cycles, pulses, ngot} = '0;
    {started, i_bus_tick, i_cmd_valid, i_cmd_write, i_cfg_narrow} = '0;
    {i_self_refresh, i_clock_stop_req, i_cmd_addr, i_backlog_max} = '0;
    i_reset = 1'b1;
    i_cfg_cas = 3'h3;
    i_cfg_banks = 2'h3;
    i_cfg_page = 2'h2;
    i_refresh_rate = 8'hFF;
    repeat (5) @(posedge i_clock);
    i_reset <= 1'b0;
    @(negedge i_clock);
    started = 1'b1;
    // Memory clock pair toggles every input cycle: half the input rate
    for (i = 0; i < 8; i++) begin
      prev = o_mem_clk;
      @(negedge i_clock);
      check(o_mem_clk, !prev);
    end
    // Every CAS code, bank, page and width setting
    for (i = 0; i < 8; i++) begin
      @(posedge i_clock);
      i_cfg_cas <= i[2:0];
      i_cfg_banks <= i[1:0];
      i_cfg_page <= i[2:1];
      i_cfg_narrow <= i[0];
      repeat (3) @(negedge i_clock);
      check(o_cfg_error, cas_bad(i));
      check(o_bank_bits, i % 4);
      check(o_col_bits, DDC_COL_BASE + i / 2);
      check(o_bus_bytes, i[0] ? DDC_BYTES_NARROW : DDC_BYTES_WIDE);
    end
    @(posedge i_clock);
    i_cfg_cas <= 3'h3;
    // Address corners, then random commands back to back
    send(1'b1, '0);
    send(1'b0, {DDC_ADDR_W{1'b1}});
    for (i = 0; i < 12; i++) begin
      r = $random(seed);
      send(r[28], r[27:0]);
    end
    repeat (40) @(negedge i_clock);
    check(expq.size(), 0);
    // Refresh every 4 memory ticks while idle: 20 in 160 cycles, each one forced
    @(posedge i_clock);
    i_refresh_rate <= 8'h03;
    i_backlog_max <= 4'h1;
    repeat (24) @(posedge i_clock);
    pulses = 0;
    repeat (160) @(posedge i_clock);
    check(pulses, 20);
    // Self refresh clears the backlog and stops refresh pulses
    i_self_refresh <= 1'b1;
    repeat (6) @(negedge i_clock);
    check(o_self_refresh, 1'b1);
    check(o_backlog, 4'h0);
    pulses = 0;
    repeat (40) @(negedge i_clock);
    check(pulses, 0);
    @(posedge i_clock);
    i_self_refresh <= 1'b0;
    repeat (4) @(negedge i_clock);
    check(o_self_refresh, 1'b0);
    // Clock stop: clock held low, queue fills and waits until release
    @(posedge i_clock);
    i_clock_stop_req <= 1'b1;
    repeat (6) @(negedge i_clock);
    check(o_clock_stop_ack, 1'b1);
    ngot = 0;
    send(1'b1, 28'h5A5A5A5);
    for (i = 0; i < 3; i++) begin
      r = $random(seed);
      send(r[28], r[27:0]);
    end
    repeat (20) @(negedge i_clock);
    check(o_cmd_ready, 1'b0);
    check(o_mem_clk, 1'b0);
    check(ngot, 0);
    @(posedge i_clock);
    i_clock_stop_req <= 1'b0;
    repeat (30) @(negedge i_clock);
    check(o_clock_stop_ack, 1'b0);
    check(expq.size(), 0);
    prev = o_mem_clk;
    @(negedge i_clock);
    check(o_mem_clk, !prev);
    finish_test();
  end
endmodule

// file: sim/ddc_mem_model.sv
// Purpose: Behavioural memory device on the far side of the clocking block
// Assumes: Commands arrive as one-cycle pulses on i_clock
// Notes:   Watches only what the memory pins would carry; never stalls
`timescale 1ns/10ps

module ddc_mem_model
  import ddc_pkg::*;
(
  input  wire logic                  i_clock,
  input  wire logic                  i_mem_clk,
  input  wire logic                  i_mem_clk_n,
  input  wire logic                  i_cmd_valid,
  input  wire logic                  i_cmd_write,
  input  wire logic [DDC_ADDR_W-1:0] i_cmd_addr,
  input  wire logic                  i_odt,
  input  wire logic                  i_dqs_diff_en,
  output logic                       o_got,
  output logic [DDC_ENTRY_W-1:0]     o_word,
  output logic                       o_fault
);
  // ==========================================================================
  // Command capture
  // ==========================================================================
  // Latch each command the way the device takes it; no back-pressure exists
  always @(posedge i_clock) begin
    o_got  <= i_cmd_valid;
    o_word <= {i_cmd_write, i_cmd_addr};
  end

  // Pin faults: termination driven, differential strobe, clock pair not inverse
  always @(posedge i_clock) begin
    o_fault <= i_odt | i_dqs_diff_en | (i_mem_clk == i_mem_clk_n);
  end
endmodule
